// *** rtl/lrad_pkg.sv ***
// Purpose: constants and carrier types for the line/rectangle decoder
// Assumes: 32-bit command words, single core clock
// Notes: command codes and some field positions live here; the decoder slices other fields inline
package lrad_pkg;
    localparam logic [2:0] OP_LINE = 3'h2;
    localparam logic [2:0] OP_RECT = 3'h3;
    localparam logic [7:0] CMD_MODE = 8'hE1;
    localparam logic [7:0] CMD_TWIN = 8'hE2;
    localparam logic [7:0] CMD_AREA_TL = 8'hE3;
    localparam logic [7:0] CMD_AREA_BR = 8'hE4;
    localparam logic [7:0] CMD_OFFS = 8'hE5;
    localparam logic [31:0] TERM_MASK = 32'hF000F000;
    localparam logic [31:0] TERM_VAL = 32'h50005000;
    localparam int B_GOUR = 28;
    localparam int B_POLY = 27;
    localparam int B_TEX = 26;
    localparam int B_SEMI = 25;
    localparam int B_Y_LO = 16;
    localparam int B_DITH = 9;
    localparam int B_FLIPX = 12;
    localparam int B_FLIPY = 13;
    localparam logic [1:0] SZ_VAR = 2'h0;
    localparam logic [1:0] SZ_ONE = 2'h1;
    localparam logic [1:0] SZ_8 = 2'h2;
    localparam logic [1:0] SZ_16 = 2'h3;
    localparam logic [10:0] MAX_DX = 11'h3FF;
    localparam logic [10:0] MAX_DY = 11'h1FF;
    localparam logic [13:0] MODE_TP_MASK = 14'h09FF;
    localparam logic [1:0] DEPTH_RES = 2'h3;
    localparam logic [1:0] DEPTH_15 = 2'h2;
    localparam logic [7:0] UNITY = 8'h80;
    localparam logic [4:0] SAT5 = 5'h1F;

    typedef struct packed {
        logic signed [10:0] y;
        logic signed [10:0] x;
    } lrad_xy_t;

    typedef struct packed {
        logic [7:0] b;
        logic [7:0] g;
        logic [7:0] r;
    } lrad_rgb_t;

    // one segment or rectangle handed to the rasterizer
    typedef struct packed {
        logic is_rect;
        logic semi;
        logic tex;
        logic dither;
        logic incl_end;
        logic flip_x;
        logic flip_y;
        lrad_rgb_t c0;
        lrad_rgb_t c1;
        lrad_xy_t p0;
        lrad_xy_t p1;
        logic [7:0] u;
        logic [7:0] v;
        logic [5:0] pal_x;
        logic [8:0] pal_y;
        logic [9:0] w;
        logic [8:0] h;
    } lrad_prim_t;

    typedef struct packed {
        logic [9:0] x1;
        logic [8:0] y1;
        logic [9:0] x2;
        logic [8:0] y2;
    } lrad_area_t;
endpackage

// *** rtl/lrad_decoder.sv ***
// Purpose: command word decoder for lines, rectangles and attributes
// Assumes: sender keeps word order; rasterizer takes prim on prim_valid
// Notes: one word per cycle; texture and clip helpers for the rasterizer
`timescale 1ns/1ps
`default_nettype none
module lrad_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_data,
    output logic cmd_ready,
    output lrad_pkg::lrad_prim_t prim,
    output logic prim_valid,
    output logic busy,
    output logic [13:0] draw_mode,
    output logic [19:0] tex_window,
    output lrad_pkg::lrad_area_t draw_area,
    output lrad_pkg::lrad_xy_t draw_offset,
    output logic [1:0] tex_depth,
    input wire logic [7:0] tc_in_u,
    input wire logic [7:0] tc_in_v,
    output logic [7:0] tc_out_u,
    output logic [7:0] tc_out_v,
    input wire lrad_pkg::lrad_xy_t pix_xy,
    output logic pix_keep,
    input wire logic [7:0] tex_comp,
    input wire logic [7:0] blend_comp,
    output logic [4:0] blend_out
);
    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_LCOL = 3'b001,
        ST_LXY = 3'b010,
        ST_RXY = 3'b011,
        ST_RUV = 3'b100,
        ST_RSZ = 3'b101
    } lrad_st_t;

    lrad_st_t st_ff, nxt_st;
    logic [31:0] cmd_ff, nxt_cmd;
    logic [1:0] nvtx_ff, nxt_nvtx;
    lrad_pkg::lrad_rgb_t col_ff, nxt_col;
    lrad_pkg::lrad_prim_t prim_ff, nxt_prim;
    logic pv_ff, nxt_pv;
    logic [13:0] mode_ff, nxt_mode;
    logic [19:0] twin_ff, nxt_twin;
    lrad_pkg::lrad_area_t area_ff, nxt_area;
    lrad_pkg::lrad_xy_t offs_ff, nxt_offs;

    // sign-extended vertex pick, offset added before any clipping
    function automatic lrad_pkg::lrad_xy_t vtx(input logic [31:0] w,
        input lrad_pkg::lrad_xy_t o);
        lrad_pkg::lrad_xy_t r;
        r.x = w[10:0] + o.x;
        r.y = w[lrad_pkg::B_Y_LO +: 11] + o.y;
        return r;
    endfunction

    // span check; out-of-range segments are silently dropped
    function automatic logic fits(input lrad_pkg::lrad_xy_t a,
        input lrad_pkg::lrad_xy_t b);
        logic [10:0] dx;
        logic [10:0] dy;
        dx = (a.x > b.x) ? 11'(a.x - b.x) : 11'(b.x - a.x);
        dy = (a.y > b.y) ? 11'(a.y - b.y) : 11'(b.y - a.y);
        return (dx <= lrad_pkg::MAX_DX) && (dy <= lrad_pkg::MAX_DY);
    endfunction

    function automatic logic [7:0] twin(input logic [7:0] c,
        input logic [4:0] m, input logic [4:0] o);
        return (c & ~{m, 3'h0}) | ({(o & m), 3'h0});
    endfunction

    assign cmd_ready = 1'b1;
    assign prim = prim_ff;
    assign prim_valid = pv_ff;
    assign busy = (st_ff != ST_CMD);
    assign draw_mode = mode_ff;
    assign tex_window = twin_ff;
    assign draw_area = area_ff;
    assign draw_offset = offs_ff;
    // reserved depth folds onto direct colour
    assign tex_depth = (mode_ff[8:7] == lrad_pkg::DEPTH_RES) ?
        lrad_pkg::DEPTH_15 : mode_ff[8:7];
    // texture window helper; fields are 5 bits, 8-pixel steps
    assign tc_out_u = twin(tc_in_u, twin_ff[4:0], twin_ff[14:10]);
    assign tc_out_v = twin(tc_in_v, twin_ff[9:5], twin_ff[19:15]);
    // clip test against inclusive drawing area corners
    assign pix_keep = (pix_xy.x >= $signed({1'b0, area_ff.x1})) &&
        (pix_xy.x <= $signed({1'b0, area_ff.x2})) &&
        (pix_xy.y >= $signed({2'b0, area_ff.y1})) &&
        (pix_xy.y <= $signed({2'b0, area_ff.y2}));

    // blend: 80h is unity, result clamps at full scale
    logic [15:0] prod;
    always_comb begin
        prod = 16'(tex_comp) * 16'(blend_comp);
        blend_out = (prod[15:7] > 9'(lrad_pkg::SAT5)) ? lrad_pkg::SAT5 :
            prod[11:7];
    end

    // word sequencer and attribute writes
    always_comb begin
        lrad_pkg::lrad_xy_t p;
        logic [7:0] op;
        p = vtx(cmd_data, offs_ff);
        op = cmd_data[31:24];
        nxt_st = st_ff;
        nxt_cmd = cmd_ff;
        nxt_nvtx = nvtx_ff;
        nxt_col = col_ff;
        nxt_prim = prim_ff;
        nxt_pv = 1'b0;
        nxt_mode = mode_ff;
        nxt_twin = twin_ff;
        nxt_area = area_ff;
        nxt_offs = offs_ff;
        if (cmd_valid) begin
            case (st_ff)
                ST_CMD: begin
                    nxt_cmd = cmd_data;
                    nxt_nvtx = 2'h0;
                    nxt_col = cmd_data[23:0];
                    if (cmd_data[31:29] == lrad_pkg::OP_LINE) begin
                        nxt_st = ST_LXY;
                    end else if (cmd_data[31:29] == lrad_pkg::OP_RECT) begin
                        nxt_st = ST_RXY;
                    end else if (op == lrad_pkg::CMD_MODE) begin
                        nxt_mode = cmd_data[13:0];
                    end else if (op == lrad_pkg::CMD_TWIN) begin
                        nxt_twin = cmd_data[19:0];
                    end else if (op == lrad_pkg::CMD_AREA_TL) begin
                        nxt_area.x1 = cmd_data[9:0];
                        nxt_area.y1 = cmd_data[18:10];
                    end else if (op == lrad_pkg::CMD_AREA_BR) begin
                        nxt_area.x2 = cmd_data[9:0];
                        nxt_area.y2 = cmd_data[18:10];
                    end else if (op == lrad_pkg::CMD_OFFS) begin
                        nxt_offs.x = cmd_data[10:0];
                        nxt_offs.y = cmd_data[21:11];
                    end
                end
                ST_LCOL: begin
                    if (cmd_ff[lrad_pkg::B_POLY] &&
                        ((cmd_data & lrad_pkg::TERM_MASK) ==
                        lrad_pkg::TERM_VAL) && nvtx_ff == 2'h2) begin
                        nxt_st = ST_CMD;
                    end else begin
                        nxt_col = cmd_data[23:0];
                        nxt_st = ST_LXY;
                    end
                end
                ST_LXY: begin
                    if (cmd_ff[lrad_pkg::B_POLY] && nvtx_ff == 2'h2 &&
                        !cmd_ff[lrad_pkg::B_GOUR] &&
                        ((cmd_data & lrad_pkg::TERM_MASK) ==
                        lrad_pkg::TERM_VAL)) begin
                        nxt_st = ST_CMD;
                    end else begin
                        nxt_prim.p0 = prim_ff.p1;
                        nxt_prim.c0 = prim_ff.c1;
                        nxt_prim.p1 = p;
                        nxt_prim.c1 = cmd_ff[lrad_pkg::B_GOUR] ? col_ff :
                            cmd_ff[23:0];
                        nxt_prim.is_rect = 1'b0;
                        nxt_prim.semi = cmd_ff[lrad_pkg::B_SEMI];
                        nxt_prim.tex = 1'b0;
                        nxt_prim.dither = mode_ff[lrad_pkg::B_DITH];
                        nxt_prim.incl_end = 1'b1;
                        nxt_prim.flip_x = 1'b0;
                        nxt_prim.flip_y = 1'b0;
                        if (nvtx_ff != 2'h0) begin
                            nxt_pv = fits(prim_ff.p1, p);
                        end
                        if (nvtx_ff != 2'h2) begin
                            nxt_nvtx = nvtx_ff + 2'h1;
                        end
                        if (!cmd_ff[lrad_pkg::B_POLY] && nvtx_ff == 2'h1) begin
                            nxt_st = ST_CMD;
                        end else begin
                            nxt_st = cmd_ff[lrad_pkg::B_GOUR] ? ST_LCOL :
                                ST_LXY;
                        end
                    end
                end
                ST_RXY: begin
                    nxt_prim.p0 = p;
                    nxt_prim.p1 = p;
                    nxt_prim.c0 = cmd_ff[23:0];
                    nxt_prim.c1 = cmd_ff[23:0];
                    nxt_prim.is_rect = 1'b1;
                    nxt_prim.semi = cmd_ff[lrad_pkg::B_SEMI];
                    nxt_prim.tex = cmd_ff[lrad_pkg::B_TEX];
                    nxt_prim.dither = 1'b0;
                    nxt_prim.incl_end = 1'b0;
                    nxt_prim.flip_x = mode_ff[lrad_pkg::B_FLIPX];
                    nxt_prim.flip_y = mode_ff[lrad_pkg::B_FLIPY];
                    case (cmd_ff[28:27])
                        lrad_pkg::SZ_ONE: begin
                            nxt_prim.w = 10'h001;
                            nxt_prim.h = 9'h001;
                        end
                        lrad_pkg::SZ_8: begin
                            nxt_prim.w = 10'h008;
                            nxt_prim.h = 9'h008;
                        end
                        lrad_pkg::SZ_16: begin
                            nxt_prim.w = 10'h010;
                            nxt_prim.h = 9'h010;
                        end
                        default: begin
                            nxt_prim.w = prim_ff.w;
                            nxt_prim.h = prim_ff.h;
                        end
                    endcase
                    if (cmd_ff[lrad_pkg::B_TEX]) begin
                        nxt_st = ST_RUV;
                    end else if (cmd_ff[28:27] == lrad_pkg::SZ_VAR) begin
                        nxt_st = ST_RSZ;
                    end else begin
                        nxt_st = ST_CMD;
                        nxt_pv = 1'b1;
                    end
                end
                ST_RUV: begin
                    nxt_prim.u = cmd_data[7:0];
                    nxt_prim.v = cmd_data[15:8];
                    nxt_prim.pal_x = cmd_data[21:16];
                    nxt_prim.pal_y = cmd_data[30:22];
                    if (cmd_ff[28:27] == lrad_pkg::SZ_VAR) begin
                        nxt_st = ST_RSZ;
                    end else begin
                        nxt_st = ST_CMD;
                        nxt_pv = 1'b1;
                    end
                end
                ST_RSZ: begin
                    // sizes beyond window repeat via texture window logic
                    nxt_prim.w = cmd_data[9:0];
                    nxt_prim.h = cmd_data[24:16];
                    nxt_st = ST_CMD;
                    nxt_pv = 1'b1;
                end
                default: nxt_st = ST_CMD;
            endcase
        end
    end

    // registers; attributes clear to zero at reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= ST_CMD;
            cmd_ff <= 32'h0;
            nvtx_ff <= 2'h0;
            col_ff <= '0;
            prim_ff <= '0;
            pv_ff <= 1'b0;
            mode_ff <= 14'h0;
            twin_ff <= 20'h0;
            area_ff <= '0;
            offs_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            cmd_ff <= nxt_cmd;
            nvtx_ff <= nxt_nvtx;
            col_ff <= nxt_col;
            prim_ff <= nxt_prim;
            pv_ff <= nxt_pv;
            mode_ff <= nxt_mode;
            twin_ff <= nxt_twin;
            area_ff <= nxt_area;
            offs_ff <= nxt_offs;
        end
    end
endmodule
`default_nettype wire

// *** test/lrad_decoder_props.sv ***
// Purpose: port-level checks for the line/rectangle decoder
// Assumes: one clock, rst_n synchronous and active low
// Notes: attribute loads are judged one cycle after the taken word
`timescale 1ns/1ps
`default_nettype none
module lrad_decoder_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_data,
    input wire logic cmd_ready,
    input wire lrad_pkg::lrad_prim_t prim,
    input wire logic prim_valid,
    input wire logic busy,
    input wire logic [13:0] draw_mode,
    input wire logic [19:0] tex_window,
    input wire lrad_pkg::lrad_area_t draw_area,
    input wire lrad_pkg::lrad_xy_t draw_offset,
    input wire logic [1:0] tex_depth,
    input wire logic [7:0] tc_in_u,
    input wire logic [7:0] tc_in_v,
    input wire logic [7:0] tc_out_u,
    input wire logic [7:0] tc_out_v,
    input wire lrad_pkg::lrad_xy_t pix_xy,
    input wire logic pix_keep,
    input wire logic [7:0] tex_comp,
    input wire logic [7:0] blend_comp,
    input wire logic [4:0] blend_out
);
    logic [31:0] word_ff;
    logic [31:0] nxt_word;
    logic [15:0] prod;
    logic env;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // last word seen, so a load can be compared a cycle later
    always_comb begin
        nxt_word = cmd_data;
    end
    always_ff @(posedge clk) begin
        word_ff <= nxt_word;
    end
    // only a word outside a primitive can be an attribute
    assign env = cmd_valid && !busy && cmd_data[31:29] == 3'h7;
    assign prod = tex_comp * blend_comp;
    a_ready_always: assert property (cmd_ready)
        else $error("word not accepted");
    a_depth_fold: assert property (tex_depth == ((draw_mode[8:7] == 2'h3)
        ? 2'h2 : draw_mode[8:7])) else $error("depth fold wrong");
    a_offset_load: assert property (env && cmd_data[31:24] == 8'hE5
        |=> draw_offset == word_ff[21:0]) else $error("offset");
    a_area_tl: assert property (env && cmd_data[31:24] == 8'hE3
        |=> {draw_area.y1, draw_area.x1} == word_ff[18:0])
        else $error("area top left");
    a_area_br: assert property (env && cmd_data[31:24] == 8'hE4
        |=> {draw_area.y2, draw_area.x2} == word_ff[18:0])
        else $error("area bottom right");
    a_window_load: assert property (env && cmd_data[31:24] == 8'hE2
        |=> tex_window == word_ff[19:0]) else $error("window");
    a_mode_load: assert property (env && cmd_data[31:24] == 8'hE1
        |=> draw_mode == word_ff[13:0]) else $error("mode");
    a_window_map: assert property (tc_out_u == ((tc_in_u &
        ~{tex_window[4:0], 3'h0}) | {tex_window[14:10] & tex_window[4:0],
        3'h0})) else $error("texcoord window");
    a_clip_keep: assert property (pix_keep == (!pix_xy.x[10] &&
        !pix_xy.y[10] && pix_xy.x[9:0] >= draw_area.x1 &&
        pix_xy.x[9:0] <= draw_area.x2 && pix_xy.y[9:0] >= {1'b0,
        draw_area.y1} && pix_xy.y[9:0] <= {1'b0, draw_area.y2}))
        else $error("clip");
    a_blend_sat: assert property (blend_out == ((prod[15:12] != 4'h0)
        ? 5'h1F : prod[11:7])) else $error("blend");
    a_rect_one: assert property (!busy && cmd_valid && cmd_data[31:26]
        == 6'h1A ##1 cmd_valid |=> prim_valid && prim.w == 10'h001 &&
        prim.h == 9'h001) else $error("pixel rect");
    a_line_flags: assert property (prim_valid && !prim.is_rect |->
        prim.incl_end && prim.dither == draw_mode[9])
        else $error("line flags");
    a_rect_plain: assert property (prim_valid && prim.is_rect |->
        !prim.dither) else $error("rect dithered");
endmodule
bind lrad_decoder lrad_decoder_props i_props (.*);
`default_nettype wire

// *** test/lrad_host.sv ***
// Purpose: word source standing for the processor or dma channel
// Assumes: one word per taken edge
// Notes: idle data toggles so a stale word never looks valid
`timescale 1ns/1ps
`default_nettype none
module lrad_host (
    input wire logic clk,
    output logic cmd_valid,
    output logic [31:0] cmd_data,
    input wire logic cmd_ready
);
    logic [31:0] q[$];
    int gap = 0;
    int idle = 0;
    initial begin
        cmd_valid = 1'b0;
        cmd_data = 32'h0;
    end
    // words leave in queue order, gap idles between them for a slow sender
    always @(posedge clk) begin
        if (cmd_valid && !cmd_ready) begin
            idle <= 0;
        end else if (q.size() > 0 && idle >= gap) begin
            cmd_valid <= 1'b1;
            cmd_data <= q.pop_front();
            idle <= 0;
        end else begin
            cmd_valid <= 1'b0;
            cmd_data <= ~cmd_data;
            idle <= idle + 1;
        end
    end
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Purpose: self-checking bench for the line/rectangle decoder
// Assumes: host model feeds words, bench drives the helper inputs
// Notes: primitives are collected by a monitor and judged per test
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid, cmd_ready, prim_valid, busy, pix_keep;
    logic [31:0] cmd_data;
    lrad_pkg::lrad_prim_t prim;
    lrad_pkg::lrad_prim_t pq[$];
    logic [13:0] draw_mode;
    logic [19:0] tex_window;
    lrad_pkg::lrad_area_t draw_area;
    lrad_pkg::lrad_xy_t draw_offset;
    lrad_pkg::lrad_xy_t pix_xy = '0;
    logic [1:0] tex_depth;
    logic [7:0] tc_in_u = 8'h00, tc_in_v = 8'h00, tc_out_u, tc_out_v;
    logic [7:0] tex_comp = 8'h00, blend_comp = 8'h00;
    logic [4:0] blend_out;
    logic [18:0] whs [4] = '{{10'h3FF, 9'h1FF}, {10'h001, 9'h001},
        {10'h008, 9'h008}, {10'h010, 9'h010}};
    int mismatches = 0;
    int compares = 0;
    always #50 clk = ~clk;
    lrad_host i_lrad_host (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready));
    lrad_decoder i_lrad_decoder (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .prim(prim), .prim_valid(prim_valid), .busy(busy),
        .draw_mode(draw_mode), .tex_window(tex_window),
        .draw_area(draw_area), .draw_offset(draw_offset),
        .tex_depth(tex_depth), .tc_in_u(tc_in_u), .tc_in_v(tc_in_v),
        .tc_out_u(tc_out_u), .tc_out_v(tc_out_v), .pix_xy(pix_xy),
        .pix_keep(pix_keep), .tex_comp(tex_comp),
        .blend_comp(blend_comp), .blend_out(blend_out));
    // prim_valid stands one cycle, so every pulse is caught here
    always @(posedge clk) begin
        if (prim_valid) pq.push_back(prim);
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // wait until every queued word is taken and its pulse has landed
    task automatic drain();
        int n;
        n = 0;
        pq.delete();
        while ((i_lrad_host.q.size() > 0 || cmd_valid) && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            close_out();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic probe(input lrad_pkg::lrad_xy_t p, input logic k,
        input logic [7:0] t, input logic [7:0] b, input logic [4:0] e);
        @(posedge clk);
        pix_xy <= p;
        tex_comp <= t;
        blend_comp <= b;
        @(posedge clk);
        #1;
        `CHK(pix_keep, k)
        `CHK(blend_out, e)
    endtask
    task automatic t_attr();
        `CHK({draw_mode, tex_window, draw_offset}, 56'h0)
        i_lrad_host.q = {32'hE1003380, 32'hE20F8823, 32'hE3008010,
            32'hE403C100, 32'hE53FE805};
        drain();
        `CHK(draw_mode, 14'h3380)
        `CHK(tex_depth, 2'h2)
        `CHK(tex_window, 20'hF8823)
        `CHK(draw_area, {10'h010, 9'h020, 10'h100, 9'h0F0})
        `CHK(draw_offset, {11'h7FD, 11'h005})
        tc_in_u <= 8'hFF;
        probe({11'h020, 11'h010}, 1'b1, 8'h80, 8'h10, 5'h10);
        `CHK({tc_out_u, tc_out_v}, 16'hF708)
        probe({11'h0F0, 11'h100}, 1'b1, 8'h80, 8'hFF, 5'h1F);
        probe({11'h020, 11'h101}, 1'b0, 8'h7F, 8'h20, 5'h1F);
        probe({11'h030, 11'h7FF}, 1'b0, 8'h00, 8'hFF, 5'h00);
        $display("attribute test done");
    endtask
    task automatic t_lines();
        i_lrad_host.q = {32'h42123456, 32'hF820F810, 32'h00400030};
        drain();
        `CHK(pq.size(), 1)
        `CHK(pq[0].c0, 24'h123456)
        `CHK(pq[0].p0, {11'h01D, 11'h015})
        `CHK(pq[0].p1, {11'h03D, 11'h035})
        `CHK({pq[0].is_rect, pq[0].semi, pq[0].incl_end, pq[0].dither},
            4'h7)
        i_lrad_host.gap = 2;
        i_lrad_host.q = {32'h58000000, 32'h0, 32'h11, 32'h00100010,
            32'h22, 32'h00200000, 32'h55555555};
        drain();
        i_lrad_host.gap = 0;
        `CHK(pq.size(), 2)
        `CHK(pq[0].c1, 24'h000011)
        `CHK(pq[1].p0, {11'h00D, 11'h015})
        `CHK(pq[1].p1, {11'h01D, 11'h005})
        `CHK(busy, 1'b0)
        i_lrad_host.q = {32'h40000000, 32'h06D40000, 32'h012C0000};
        drain();
        `CHK(pq.size(), 0)
        $display("line test done");
    endtask
    task automatic t_rect();
        logic [1:0] c;
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            i_lrad_host.q = {32'h64000000 | {3'h0, c, 27'h0}, 32'h00300020,
                32'h7FFF3412};
            if (c == lrad_pkg::SZ_VAR) i_lrad_host.q.push_back(32'h01FF03FF);
            drain();
            `CHK(pq.size(), 1)
            `CHK({pq[0].w, pq[0].h}, whs[k])
            `CHK({pq[0].u, pq[0].v}, 16'h1234)
            `CHK({pq[0].pal_x, pq[0].pal_y}, {6'h3F, 9'h1FF})
            `CHK({pq[0].is_rect, pq[0].tex, pq[0].dither, pq[0].flip_x,
                pq[0].flip_y}, 5'h1B)
            `CHK(pq[0].p0, {11'h02D, 11'h025})
        end
        i_lrad_host.q = {32'h68FF0000, 32'h00000000};
        drain();
        `CHK({pq.size() == 1, pq[0].w, pq[0].h}, {1'b1, 10'h1, 9'h1})
        $display("rectangle test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_attr();
        t_lines();
        t_rect();
        close_out();
    end
endmodule
`default_nettype wire
